// ---- core/pfcd_cycle.sv ----
/*
  One timed flash bus cycle, read or write, on the chip-select, output-gate
  and write-strobe pins. Assumes start only while idle; done is a pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module pfcd_cycle (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        wr,
  input  wire logic        hv,
  input  wire logic [17:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [7:0]  dq_i,
  output logic      [17:0] a_o,
  output logic      [7:0]  dq_o,
  output logic             dq_oe_n,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic             hv_o,
  output logic      [7:0]  rdata,
  output logic             done
);
  import pfcd_pkg::*;
  typedef enum logic [2:0] {
    PH_IDLE = 3'h1, PH_ACT = 3'h2, PH_REC = 3'h4
  } pfcd_phase_t;
  pfcd_phase_t           ph_r;
  logic [PFCD_CNT_W-1:0] cnt_r;
  logic                  wr_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_r    <= PH_IDLE;
      cnt_r   <= '0;
      wr_r    <= 1'b0;
      done    <= 1'b0;
      ce_n    <= 1'b1;
      oe_n    <= 1'b1;
      we_n    <= 1'b1;
      dq_oe_n <= 1'b1;
      hv_o    <= 1'b0;
      a_o     <= '0;
      dq_o    <= '0;
      rdata   <= '0;
    end else begin
      done <= 1'b0;
      case (ph_r)
        PH_IDLE: if (start) begin
          a_o     <= addr;
          dq_o    <= wdata;
          wr_r    <= wr;
          hv_o    <= hv && !wr;
          ce_n    <= 1'b0;
          we_n    <= !wr;
          oe_n    <= wr;
          dq_oe_n <= !wr;
          cnt_r   <= wr ? PFCD_CNT_W'(PFCD_TWP_CYC - 1) : PFCD_CNT_W'(PFCD_TRD_CYC - 1);
          ph_r    <= PH_ACT;
        end
        PH_ACT: if (cnt_r == '0) begin
          ce_n  <= 1'b1;
          oe_n  <= 1'b1;
          we_n  <= 1'b1;
          if (!wr_r) rdata <= dq_i;
          cnt_r <= PFCD_CNT_W'(PFCD_TREC_CYC - 1);
          ph_r  <= PH_REC;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
        PH_REC: begin
          // Data held one cycle past the strobe's rising edge
          dq_oe_n <= 1'b1;
          if (cnt_r == '0) begin
            hv_o <= 1'b0;
            done <= 1'b1;
            ph_r <= PH_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: ph_r <= PH_IDLE;
      endcase
    end
  end
endmodule : pfcd_cycle
`default_nettype wire

// ---- core/pfcd_host.sv ----
/*
  Host controller for a byte-wide flash: software writes an operation over
  classic Wishbone, and the block plays the unlock sequences, reads, pauses
  and toggle polling on the flash pins. Assumes the flash pins are wired
  straight to the part and the high-voltage switch follows FL_HV_ID.
*/
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module pfcd_host #(
  parameter int LOCK_PAUSE_US = pfcd_pkg::PFCD_T_LOCK_MS * 1000
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic      [17:0] FL_ADDR,
  input  wire logic [7:0]  FL_DQ_I,
  output logic      [7:0]  FL_DQ_O,
  output logic             FL_DQ_OE_N,
  output logic             FL_CE_N,
  output logic             FL_OE_N,
  output logic             FL_WE_N,
  output logic             FL_HV_ID
);
  import pfcd_pkg::*;

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01, S_CMD  = 6'h02, S_CWAIT = 6'h04,
    S_PAUSE = 6'h08, S_POLL = 6'h10, S_PWAIT = 6'h20
  } pfcd_state_t;

  pfcd_state_t           state_r, state_nxt;
  pfcd_op_t              op_r, op_in;
  logic [2:0]            idx_r;
  logic [17:0]           addr_r;
  logic [7:0]            wdata_r, rdata_r, eng_rd;
  logic                  id_mode_r, prot_r, poll_have_r, poll_prev_r, ack_r;
  logic                  wb_req, ctrl_wr, start_ok, last_w;
  logic                  eng_go, eng_wr, eng_hv, eng_done, tmr_go, tmr_done;
  logic [25:0]           word_w;
  logic [17:0]           eng_addr;
  logic [PFCD_TMR_W-1:0] tmr_len;

  assign wb_req   = WB_CYC_I && WB_STB_I && !ack_r;
  assign ctrl_wr  = wb_req && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == PFCD_REG_CTRL);
  assign op_in    = pfcd_op_t'(WB_DAT_I[3:0]);
  // Orders arriving while busy are dropped; software checks the busy flag
  assign start_ok = ctrl_wr && (state_r == S_IDLE) && (op_in != OP_NONE) && (op_in <= OP_POLL);
  assign WB_ACK_O = ack_r;

  always_comb begin
    word_w   = pfcd_seq_word(op_r, idx_r, addr_r, wdata_r);
    last_w   = (idx_r == pfcd_seq_len(op_r) - 3'h1);
    eng_go   = (state_r == S_CMD) || (state_r == S_POLL);
    eng_wr   = (state_r == S_CMD) && pfcd_is_write(op_r);
    eng_hv   = (state_r == S_CMD) && (op_r == OP_HVID);
    eng_addr = (state_r == S_POLL) ? addr_r : word_w[25:8];
  end

  always_comb begin
    state_nxt = state_r;
    tmr_go    = 1'b0;
    tmr_len   = PFCD_TMR_W'(PFCD_T_ID_US);
    case (state_r)
      S_IDLE: begin
        if (start_ok) state_nxt = (op_in == OP_POLL) ? S_POLL : S_CMD;
      end
      S_CMD: state_nxt = S_CWAIT;
      S_CWAIT: begin
        if (eng_done) begin
          if (!last_w) begin
            state_nxt = S_CMD;
          end else if (op_r == OP_ID3 || op_r == OP_ID6 || op_r == OP_IDX) begin
            state_nxt = S_PAUSE;
            tmr_go    = 1'b1;
          end else if (op_r == OP_LOCKF || op_r == OP_LOCKL) begin
            state_nxt = S_PAUSE;
            tmr_go    = 1'b1;
            tmr_len   = PFCD_TMR_W'(LOCK_PAUSE_US);
          end else if (pfcd_is_write(op_r)) begin
            state_nxt = S_POLL;
          end else begin
            state_nxt = S_IDLE;
          end
        end
      end
      S_POLL: state_nxt = S_PWAIT;
      S_PWAIT: begin
        if (eng_done) begin
          // Two equal toggle bits in a row mean the internal write is over
          if (poll_have_r && eng_rd[PFCD_TOG_BIT] == poll_prev_r) state_nxt = S_IDLE;
          else state_nxt = S_POLL;
        end
      end
      S_PAUSE: begin
        if (tmr_done) state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) state_r <= S_IDLE;
    else        state_r <= state_nxt;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      op_r  <= OP_NONE;
      idx_r <= '0;
    end else if (state_r == S_IDLE && start_ok) begin
      op_r  <= op_in;
      idx_r <= '0;
    end else if (state_r == S_CWAIT && eng_done && !last_w) begin
      idx_r <= idx_r + 3'h1;
    end
  end

  // Host-side view of the part's modes; power-up assumes normal mode
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      id_mode_r <= 1'b0;
      prot_r    <= 1'b0;
    end else if (state_r == S_CWAIT && eng_done && last_w) begin
      if (op_r == OP_ID3 || op_r == OP_ID6) id_mode_r <= 1'b1;
      if (op_r == OP_IDX)                   id_mode_r <= 1'b0;
      if (op_r == OP_PWRITE)                prot_r    <= 1'b1;
      if (op_r == OP_PDIS)                  prot_r    <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rdata_r     <= '0;
      poll_have_r <= 1'b0;
      poll_prev_r <= 1'b0;
    end else if (state_r == S_IDLE && start_ok) begin
      poll_have_r <= 1'b0;
    end else if (eng_done && state_r == S_PWAIT) begin
      rdata_r     <= eng_rd;
      poll_have_r <= 1'b1;
      poll_prev_r <= eng_rd[PFCD_TOG_BIT];
    end else if (eng_done && state_r == S_CWAIT && !pfcd_is_write(op_r)) begin
      rdata_r <= eng_rd;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) ack_r <= 1'b0;
    else        ack_r <= wb_req;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      addr_r  <= '0;
      wdata_r <= '0;
    end else if (wb_req && WB_WE_I && state_r == S_IDLE) begin
      if (WB_ADR_I == PFCD_REG_ADDR) begin
        if (WB_SEL_I[0]) addr_r[7:0]   <= WB_DAT_I[7:0];
        if (WB_SEL_I[1]) addr_r[15:8]  <= WB_DAT_I[15:8];
        if (WB_SEL_I[2]) addr_r[17:16] <= WB_DAT_I[17:16];
      end
      if (WB_ADR_I == PFCD_REG_WDATA && WB_SEL_I[0]) wdata_r <= WB_DAT_I[7:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      WB_DAT_O <= '0;
    end else if (wb_req) begin
      case (WB_ADR_I)
        PFCD_REG_CTRL:  WB_DAT_O <= {28'h0000000, op_r};
        PFCD_REG_ADDR:  WB_DAT_O <= {14'h0000, addr_r};
        PFCD_REG_WDATA: WB_DAT_O <= {24'h000000, wdata_r};
        PFCD_REG_STAT:  WB_DAT_O <= {21'h000000, prot_r, id_mode_r,
                                     state_r != S_IDLE, rdata_r};
        default:        WB_DAT_O <= '0;
      endcase
    end
  end

  pfcd_cycle pfcd_cycle_inst (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .start   (eng_go),
    .wr      (eng_wr),
    .hv      (eng_hv),
    .addr    (eng_addr),
    .wdata   (word_w[7:0]),
    .dq_i    (FL_DQ_I),
    .a_o     (FL_ADDR),
    .dq_o    (FL_DQ_O),
    .dq_oe_n (FL_DQ_OE_N),
    .ce_n    (FL_CE_N),
    .oe_n    (FL_OE_N),
    .we_n    (FL_WE_N),
    .hv_o    (FL_HV_ID),
    .rdata   (eng_rd),
    .done    (eng_done)
  );

  pfcd_timer pfcd_timer_inst (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .start (tmr_go),
    .len   (tmr_len),
    .done  (tmr_done)
  );

  property p_first_word;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == S_CMD && idx_r == 3'h0 && pfcd_seq_len(op_r) > 3'h1)
        |-> (eng_addr == PFCD_A_5555 && word_w[7:0] == PFCD_D_AA) ##1 !FL_WE_N;
  endproperty
  a_first_word: assert property (p_first_word) else $error("bad first unlock word");

  property p_second_word;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == S_CMD && idx_r == 3'h1 && pfcd_seq_len(op_r) > 3'h1)
        |-> ##1 (FL_ADDR == PFCD_A_2AAA && FL_DQ_O == PFCD_D_55 && !FL_WE_N);
  endproperty
  a_second_word: assert property (p_second_word) else $error("bad second unlock word");

  property p_id3;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == S_CMD && op_r == OP_ID3 && idx_r == 3'h2) |-> ##1 FL_DQ_O == PFCD_D_90;
  endproperty
  a_id3: assert property (p_id3) else $error("short id entry code wrong");

  property p_id6;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == S_CMD && op_r == OP_ID6 && idx_r == 3'h5) |-> ##1 FL_DQ_O == PFCD_D_60;
  endproperty
  a_id6: assert property (p_id6) else $error("long id entry code wrong");

  property p_idx;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == S_CMD && op_r == OP_IDX && idx_r == 3'h2) |-> ##1 FL_DQ_O == PFCD_D_F0;
  endproperty
  a_idx: assert property (p_idx) else $error("id exit code wrong");

  property p_prot;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == S_CMD && op_r == OP_PWRITE && idx_r == 3'h2)
        |-> ##1 (FL_DQ_O == PFCD_D_A0 && FL_ADDR == PFCD_A_5555);
  endproperty
  a_prot: assert property (p_prot) else $error("protect code wrong");

  property p_pdis_erase;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == S_CMD && idx_r == 3'h5 && (op_r == OP_PDIS || op_r == OP_ERASE))
        |-> ##1 FL_DQ_O == ((op_r == OP_PDIS) ? PFCD_D_20 : PFCD_D_10);
  endproperty
  a_pdis_erase: assert property (p_pdis_erase) else $error("sixth code wrong");

  property p_lock_last;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == S_CMD && op_r == OP_LOCKL && idx_r == 3'h6)
        |-> ##1 (FL_ADDR == PFCD_A_LAST && FL_DQ_O == PFCD_D_FF);
  endproperty
  a_lock_last: assert property (p_lock_last) else $error("lock word wrong");

  property p_lock_pause;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (tmr_go && (op_r == OP_LOCKF || op_r == OP_LOCKL))
        |-> tmr_len == PFCD_TMR_W'(LOCK_PAUSE_US) ##1 (state_r == S_PAUSE) [*8];
  endproperty
  a_lock_pause: assert property (p_lock_pause) else $error("lock pause cut short");

  property p_write_pins;
    @(posedge CORE_CLK) disable iff (!RST_N)
      !FL_WE_N |-> (!FL_CE_N && FL_OE_N && !FL_DQ_OE_N && !FL_HV_ID);
  endproperty
  a_write_pins: assert property (p_write_pins) else $error("write strobe misuse");

  property p_read_pins;
    @(posedge CORE_CLK) disable iff (!RST_N)
      !FL_OE_N |-> (!FL_CE_N && FL_WE_N && FL_DQ_OE_N);
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("read drives data bus");

  c_id3:  cover property (@(posedge CORE_CLK) state_r == S_PAUSE && op_r == OP_ID3);
  c_lock: cover property (@(posedge CORE_CLK) tmr_done && op_r == OP_LOCKL);
  c_poll: cover property (@(posedge CORE_CLK) state_r == S_PWAIT ##1 state_r == S_POLL);
  c_hvid: cover property (@(posedge CORE_CLK) FL_HV_ID && !FL_OE_N);
endmodule : pfcd_host
`default_nettype wire

// ---- core/pfcd_pkg.sv ----
/*
  Constants, command codes, operation codes and command-word decoding for
  the parallel flash command host. Assumes a 25 MHz core clock.
*/
package pfcd_pkg;
  localparam int PFCD_CLK_NS    = 40;
  localparam int PFCD_TWP_NS    = 70;
  localparam int PFCD_TWPH_NS   = 100;
  localparam int PFCD_TACC_NS   = 120;
  localparam int PFCD_TWP_CYC   = (PFCD_TWP_NS + PFCD_CLK_NS - 1) / PFCD_CLK_NS;
  localparam int PFCD_TREC_CYC  = (PFCD_TWPH_NS + PFCD_CLK_NS - 1) / PFCD_CLK_NS;
  // One extra cycle of margin for board delay on reads
  localparam int PFCD_TRD_CYC   = (PFCD_TACC_NS + PFCD_CLK_NS - 1) / PFCD_CLK_NS + 1;
  localparam int PFCD_US_CYC    = 1000 / PFCD_CLK_NS;
  localparam int PFCD_T_ID_US   = 10;
  localparam int PFCD_T_LOCK_MS = 10;
  localparam int PFCD_TMR_W     = 14;
  localparam int PFCD_DIV_W     = 5;
  localparam int PFCD_CNT_W     = 3;

  localparam logic [17:0] PFCD_A_5555  = 18'h05555;
  localparam logic [17:0] PFCD_A_2AAA  = 18'h02aaa;
  localparam logic [17:0] PFCD_A_ZERO  = 18'h00000;
  localparam logic [17:0] PFCD_A_LAST  = 18'h3ffff;
  localparam logic [17:0] PFCD_A_CMASK = 18'h07fff;
  localparam logic [7:0]  PFCD_D_AA = 8'haa;
  localparam logic [7:0]  PFCD_D_55 = 8'h55;
  localparam logic [7:0]  PFCD_D_80 = 8'h80;
  localparam logic [7:0]  PFCD_D_90 = 8'h90;
  localparam logic [7:0]  PFCD_D_60 = 8'h60;
  localparam logic [7:0]  PFCD_D_F0 = 8'hf0;
  localparam logic [7:0]  PFCD_D_A0 = 8'ha0;
  localparam logic [7:0]  PFCD_D_20 = 8'h20;
  localparam logic [7:0]  PFCD_D_10 = 8'h10;
  localparam logic [7:0]  PFCD_D_40 = 8'h40;
  localparam logic [7:0]  PFCD_D_00 = 8'h00;
  localparam logic [7:0]  PFCD_D_FF = 8'hff;

  localparam logic [3:0] PFCD_REG_CTRL  = 4'h0;
  localparam logic [3:0] PFCD_REG_ADDR  = 4'h4;
  localparam logic [3:0] PFCD_REG_WDATA = 4'h8;
  localparam logic [3:0] PFCD_REG_STAT  = 4'hc;
  localparam int PFCD_TOG_BIT = 6;

  typedef enum logic [3:0] {
    OP_NONE  = 4'h0, OP_READ  = 4'h1, OP_WRITE = 4'h2, OP_PWRITE = 4'h3,
    OP_ID3   = 4'h4, OP_ID6   = 4'h5, OP_IDX   = 4'h6, OP_PDIS   = 4'h7,
    OP_ERASE = 4'h8, OP_LOCKF = 4'h9, OP_LOCKL = 4'ha, OP_HVID   = 4'hb,
    OP_POLL  = 4'hc
  } pfcd_op_t;

  function automatic logic pfcd_is_write(input pfcd_op_t op);
    return !(op == OP_READ || op == OP_HVID || op == OP_POLL);
  endfunction : pfcd_is_write

  function automatic logic [2:0] pfcd_seq_len(input pfcd_op_t op);
    case (op)
      OP_PWRITE:                   return 3'h4;
      OP_IDX, OP_ID3:              return 3'h3;
      OP_ID6, OP_PDIS, OP_ERASE:   return 3'h6;
      OP_LOCKF, OP_LOCKL:          return 3'h7;
      default:                     return 3'h1;
    endcase
  endfunction : pfcd_seq_len

  // Word = {address, data}; prefix addresses kept inside A14..A0
  function automatic logic [25:0] pfcd_seq_word(input pfcd_op_t op, input logic [2:0] idx,
                                                input logic [17:0] ua, input logic [7:0] ud);
    logic [25:0] w;
    w = {PFCD_A_5555 & PFCD_A_CMASK, PFCD_D_AA};
    case (idx)
      3'h1, 3'h4: w = {PFCD_A_2AAA & PFCD_A_CMASK, PFCD_D_55};
      3'h2: begin
        case (op)
          OP_ID3:    w[7:0] = PFCD_D_90;
          OP_IDX:    w[7:0] = PFCD_D_F0;
          OP_PWRITE: w[7:0] = PFCD_D_A0;
          default:   w[7:0] = PFCD_D_80;
        endcase
      end
      3'h5: begin
        case (op)
          OP_ID6:   w[7:0] = PFCD_D_60;
          OP_PDIS:  w[7:0] = PFCD_D_20;
          OP_ERASE: w[7:0] = PFCD_D_10;
          default:  w[7:0] = PFCD_D_40;
        endcase
      end
      3'h6: w = (op == OP_LOCKL) ? {PFCD_A_LAST, PFCD_D_FF} : {PFCD_A_ZERO, PFCD_D_00};
      default: w = {PFCD_A_5555 & PFCD_A_CMASK, PFCD_D_AA};
    endcase
    if (!pfcd_is_write(op) || op == OP_WRITE || (op == OP_PWRITE && idx == 3'h3)) begin
      w = {ua, ud};
    end
    return w;
  endfunction : pfcd_seq_word
endpackage : pfcd_pkg

// ---- core/pfcd_timer.sv ----
/*
  Microsecond pause timer: a divider gives a one-cycle tick each
  microsecond, and a down-counter ends the pause. Assumes len is nonzero.
*/
`timescale 1ns/10ps
`default_nettype none
module pfcd_timer (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            start,
  input  wire logic [pfcd_pkg::PFCD_TMR_W-1:0] len,
  output logic                                 done
);
  import pfcd_pkg::*;
  logic [PFCD_DIV_W-1:0] div_r;
  logic [PFCD_TMR_W-1:0] left_r;
  logic                  run_r;
  logic                  tick;

  assign tick = run_r && (div_r == PFCD_DIV_W'(PFCD_US_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rst_n || start || tick) div_r <= '0;
    else if (run_r)              div_r <= div_r + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_r  <= 1'b0;
      left_r <= '0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        run_r  <= 1'b1;
        left_r <= len;
      end else if (tick) begin
        left_r <= left_r - 1'b1;
        if (left_r == PFCD_TMR_W'(1)) begin
          run_r <= 1'b0;
          done  <= 1'b1;
        end
      end
    end
  end
endmodule : pfcd_timer
`default_nettype wire

// ---- verif/pfcd_flash_model.sv ----
/* Flash model: command decoder, identification, lockout, toggle status.
   Assumes the host drives DQ only during its write cycles. */
`timescale 1ns/10ps
`default_nettype none
module pfcd_flash_model #(
  parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value
  parameter logic [7:0] PART  = 8'hc3, // Arbitrary value
  parameter int         BUSY  = 2000
) (
  input  wire logic [17:0] a,
  input  wire logic [7:0]  din,
  input  wire logic        hoe_n,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        hv,
  output logic      [7:0]  dq
);
  logic [7:0]  mem [0:262143];
  logic [22:0] h [0:4] = '{default: 23'h0};
  logic        id = 1'b0, prot = 1'b1, pl = 1'b0, arm = 1'b0;
  logic        lkf = 1'b0, lkl = 1'b0, tog = 1'b0, busy = 1'b0;
  logic [7:0]  rel = 8'h00;
  logic [7:0]  q;
  wire  [22:0] w = {a[14:0], din};
  wire         p3 = h[1] == 23'h5555aa && h[0] == 23'h2aaa55;
  wire         p6 = p3 && h[4] == 23'h5555aa && h[3] == 23'h2aaa55 && h[2] == 23'h555580;
  wire         c5 = a[14:0] == 15'h5555;
  wire         drv = !ce_n && !oe_n && we_n;
  // Case equality keeps the unknown strobes before reset from faking a write
  wire         wsel = ce_n === 1'b0 && oe_n === 1'b1 && we_n === 1'b0;
  wire         lk = (lkf && a < 18'h02000) || (lkl && a >= 18'h3e000);
  initial foreach (mem[i]) mem[i] = 8'hff;
  // Data latched on the first of select or strobe rising; both may rise together
  always @(negedge wsel) begin
    if (arm) begin
      lkf = lkf || w == 23'h0;
      lkl = lkl || w == 23'h7fffff;
      arm = 1'b0;
    end else if (p6 && c5) begin
      id = id || din == 8'h60;
      prot = prot && din != 8'h20;
      arm = din == 8'h40;
      busy = din == 8'h10 && !(lkf || lkl);
      if (busy) foreach (mem[i]) mem[i] = 8'hff;
    end else if (p3 && c5 && din inside {8'h90, 8'hf0, 8'ha0}) begin
      id = din == 8'h90;
      pl = din == 8'ha0;
      prot = prot || pl;
    end else if (!c5 && a[14:0] != 15'h2aaa && (!prot || pl) && !lk) begin
      mem[a] = din;
      pl = 1'b0;
      busy = 1'b1;
    end
    // Mismatching words just age out of the history
    for (int i = 4; i > 0; i--) h[i] = h[i-1];
    h[0] = w;
    if (busy) busy <= #(BUSY) 1'b0;
  end
  always @(posedge drv) if (busy) tog = ~tog;
  // Released bus shows the inverse, never a stale match
  always @(negedge drv) rel = ~q;
  assign q = busy ? {1'b0, tog, 6'h0} : !(id || hv) ? mem[a] : !a[1] ? (a[0] ? PART : MAKER)
           : (a[17] ? lkl : lkf) ? 8'hff : 8'hfe;
  assign dq = !hoe_n ? din : drv ? q : rel;
endmodule : pfcd_flash_model
`default_nettype wire

// ---- verif/pfcd_host_bench.sv ----
/* Bench: Wishbone orders to the host, flash model on the pins.
   Assumes pfcd_flash_model on the far side. */
`timescale 1ns/10ps
`default_nettype none
module pfcd_host_bench;
  import pfcd_pkg::*;
  localparam logic [7:0] MK = 8'h3c;
  localparam logic [7:0] PT = 8'hc3;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0, dato, q;
  logic        ack, ce_n, oe_n, we_n, doe_n, hv;
  logic [17:0] fa;
  logic [7:0]  dqo, dqi;
  int          num_errors = 0, checks_done = 0, n;
  pfcd_host #(.LOCK_PAUSE_US(4)) pfcd_host_inst (
    .CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dato), .WB_ACK_O(ack),
    .FL_ADDR(fa), .FL_DQ_I(dqi), .FL_DQ_O(dqo), .FL_DQ_OE_N(doe_n), .FL_CE_N(ce_n),
    .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_HV_ID(hv));
  pfcd_flash_model #(.MAKER(MK), .PART(PT)) pfcd_flash_model_inst (.a(fa), .din(dqo),
    .hoe_n(doe_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .hv(hv), .dq(dqi));
  task automatic stop_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      num_errors++;
      stop_test();
    end
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Polls status until the order is finished; n counts the polls
  task automatic op(input logic [3:0] c, input logic [17:0] a, input logic [7:0] d);
    wb(1'b1, PFCD_REG_ADDR, {14'h0, a});
    wb(1'b1, PFCD_REG_WDATA, {24'h0, d});
    wb(1'b1, PFCD_REG_CTRL, {28'h0, c});
    n = 0;
    do begin
      wb(1'b0, PFCD_REG_STAT, 32'h0);
      n++;
    end while (q[8] !== 1'b0 && n < 4000);
    if (n >= 4000) begin
      num_errors++;
      stop_test();
    end
  endtask : op
  task automatic rd(input logic [17:0] a, input logic [7:0] e);
    op(4'h1, a, 8'h00);
    chk("read data", {24'h0, e}, {24'h0, q[7:0]});
  endtask : rd
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk("idle strobes", 32'h7, {29'h0, ce_n, oe_n, we_n});
    op(4'h4, 18'h0, 8'h00);
    chk("id pause", 32'h1, {31'h0, n >= 75});
    chk("mode flags", 32'h1, {30'h0, q[10:9]});
    rd(18'h0, MK);
    // Last read word held the maker code, so a stale answer would show
    wb(1'b0, 4'h6, 32'h0);
    chk("unmapped", 32'h0, q);
    rd(18'h1, PT);
    rd(18'h2, 8'hfe);
    rd(18'h3fff2, 8'hfe);
    op(4'h6, 18'h0, 8'h00);
    chk("mode flags", 32'h0, {30'h0, q[10:9]});
    rd(18'h0, 8'hff);
    op(4'h5, 18'h0, 8'h00);
    chk("id6 pause", 32'h1, {31'h0, n >= 75});
    rd(18'h1, PT);
    op(4'h6, 18'h0, 8'h00);
    op(4'hb, 18'h1, 8'h00);
    chk("hv id", {24'h0, PT}, {24'h0, q[7:0]});
    op(4'h2, 18'h10, 8'h5a);
    rd(18'h10, 8'hff);
    op(4'h3, 18'h10, 8'h5a);
    chk("toggle wait", 32'h1, {31'h0, n >= 12});
    chk("mode flags", 32'h2, {30'h0, q[10:9]});
    rd(18'h10, 8'h5a);
    op(4'h7, 18'h0, 8'h00);
    chk("mode flags", 32'h0, {30'h0, q[10:9]});
    op(4'h2, 18'h11, 8'h3c);
    rd(18'h11, 8'h3c);
    op(4'h8, 18'h0, 8'h00);
    rd(18'h11, 8'hff);
    op(4'h9, 18'h0, 8'h00);
    chk("lock pause", 32'h1, {31'h0, n >= 30});
    op(4'h2, 18'h4000, 8'h77);
    op(4'h2, 18'h30, 8'h66);
    rd(18'h30, 8'hff);
    op(4'h8, 18'h0, 8'h00);
    rd(18'h4000, 8'h77);
    op(4'ha, 18'h0, 8'h00);
    op(4'h4, 18'h0, 8'h00);
    rd(18'h2, 8'hff);
    rd(18'h3fff2, 8'hff);
    op(4'hc, 18'h4000, 8'h00);
    chk("poll idle", 32'h0, {31'h0, q[8]});
    chk("poll data", {24'h0, MK}, {24'h0, q[7:0]});
    stop_test();
  end
endmodule : pfcd_host_bench
`default_nettype wire
